// file: ialu_pkg.sv
package ialu_pkg;

    // ==========================================================
    // Opcodes
    localparam logic [7:0] OP_SUB_B2    = 8'h82;
    localparam logic [7:0] OP_SUB_B3    = 8'h83;
    localparam logic [7:0] OP_SUB_W2    = 8'hA2;
    localparam logic [7:0] OP_SUB_W3    = 8'hA3;
    localparam logic [7:0] OP_SUB_L2    = 8'hC2;
    localparam logic [7:0] OP_SUB_L3    = 8'hC3;
    localparam logic [7:0] OP_PROBE_B   = 8'h95;
    localparam logic [7:0] OP_PROBE_W   = 8'hB5;
    localparam logic [7:0] OP_PROBE_L   = 8'hD5;
    localparam logic [7:0] OP_EXOR_B2   = 8'h8C;
    localparam logic [7:0] OP_EXOR_B3   = 8'h8D;
    localparam logic [7:0] OP_EXOR_W2   = 8'hAC;
    localparam logic [7:0] OP_EXOR_W3   = 8'hAD;
    localparam logic [7:0] OP_EXOR_L2   = 8'hCC;
    localparam logic [7:0] OP_EXOR_L3   = 8'hCD;
    localparam logic [7:0] OP_EAM_B     = 8'h9E;
    localparam logic [7:0] OP_EAM_W     = 8'h3E;
    localparam logic [7:0] OP_EAM_L     = 8'hDE;
    localparam logic [7:0] OP_EAM_Q     = 8'h7E;
    localparam logic [7:0] OP_EAS_B     = 8'h9F;
    localparam logic [7:0] OP_EAS_W     = 8'h3F;
    localparam logic [7:0] OP_EAS_L     = 8'hDF;
    localparam logic [7:0] OP_EAS_Q     = 8'h7F;
    localparam logic [7:0] OP_EXT_PFX   = 8'hFD;
    localparam logic [7:0] OP_SCMP_S    = 8'hEC;
    localparam logic [7:0] OP_SCMP_U    = 8'hED;
    localparam logic [7:0] OP_SIGN_WIDEN_S    = 8'hEE;
    localparam logic [7:0] OP_SIGN_WIDEN_U    = 8'hEF;

    // ==========================================================
    // Field limits and context sizes
    localparam logic [7:0] FIELD_MAX_SIZE = 8'h20;
    localparam logic [31:0] FIELD_MAX_POS = 32'h0000_001F;
    localparam logic [5:0] FIELD_REG_BITS = 6'h20;
    localparam logic [4:0] CTX_BYTE = 5'h01;
    localparam logic [4:0] CTX_WORD = 5'h02;
    localparam logic [4:0] CTX_LONG = 5'h04;
    localparam logic [4:0] CTX_QUAD = 5'h08;
    localparam logic [4:0] CTX_OCTA = 5'h10;
    localparam logic [31:0] LONG_BYTES = 32'h0000_0004;

    // ==========================================================
    // Register map (byte addresses) and reset values
    localparam logic [3:0] ADDR_STATUS = 4'h0;
    localparam logic [3:0] ADDR_MASK   = 4'h4;
    localparam logic [3:0] ADDR_OPCNT  = 4'h8;
    localparam logic [2:0] MASK_RESET  = 3'h0;
    localparam int EV_DONE  = 0;
    localparam int EV_FAULT = 1;
    localparam int EV_OVF   = 2;

    typedef enum logic [1:0] {
        IALU_IDLE = 2'b01,
        IALU_BUSY = 2'b10
    } ialu_state_t;

endpackage

// file: ialu_core.sv
`timescale 1ns/1ps
// Contract
// - Decode subtract byte/word/long; odd opcode three-operand, even two-operand.
// - Two-operand: dif minus sub; three-operand: minuend minus sub into destination.
// - Overflow when inputs differ in sign and result sign equals subtrahend sign.
// - Subtract carry is borrow from MSB; N, Z from result; V signed overflow.
// - Flag probe sets N, Z from source, clears V and C; three sizes.
// - Exclusive-OR mask with destination or source; N, Z result, V clear, C kept.
// - Address move writes effective address without access; N, Z from address.
// - Address context from data size; quad one-byte opcode, octa uses prefix.
// - Address push decrements stack pointer, stores address; flags like address move.
// - Field size above 32 raises reserved operand fault.
// - Register field with nonzero size needs position 0 to 31, else fault.
// - Memory field byte address is base plus sign-extended pos[31:3]; offset pos[2:0].
// - Register field uses Rn if pos+size at most 32, else Rn+1:Rn.
// - Memory field touches 1+((size-1+pos[2:0])/8) bytes, none for size zero.
// - Field compare extends field (zero if size 0) against source; flags only.
// - Compare flags: N signed less, Z equal, C unsigned less, V clear.
// - Compare faults on size over 32 or register position over 31 nonzero size.
// - Extract writes extended field or zero; N, Z from result, V clear, C kept.
// - Signed and unsigned extract are two adjacent single-byte opcodes.
module ialu_core
    import ialu_pkg::*;
(
    input  wire logic        mclk_in,
    input  wire logic        nrst_in,
    input  wire logic        op_valid_in,
    input  wire logic [7:0]  opcode_in,
    input  wire logic        prefix_in,
    input  wire logic [31:0] opa_in,
    input  wire logic [31:0] opb_in,
    input  wire logic [31:0] opc_in,
    input  wire logic [31:0] pos_in,
    input  wire logic [7:0]  size_in,
    input  wire logic        base_is_reg_in,
    input  wire logic [31:0] reg_lo_in,
    input  wire logic [31:0] reg_hi_in,
    input  wire logic [63:0] mem_data_in,
    input  wire logic [31:0] stack_pointer_in,
    input  wire logic [3:0]  flags_in,
    input  wire logic [3:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    output logic             done_out,
    output logic [31:0]      result_out,
    output logic             result_we_out,
    output logic [3:0]       flags_out,
    output logic             fault_out,
    output logic [31:0]      field_addr_out,
    output logic [2:0]       field_bytes_out,
    output logic [31:0]      stack_pointer_out,
    output logic             stack_we_out,
    output logic [31:0]      avs_readdata_out,
    output logic             avs_waitrequest_out,
    output logic             irq_out
);

    // ==========================================================
    // Decode
    logic [4:0]  sz;
    logic        is_sub;
    logic        is_probe;
    logic        is_exor;
    logic        is_eam;
    logic        is_eas;
    logic        is_cmp;
    logic        is_ext;
    logic        signed_fld;
    logic [4:0]  ctx;

    always_comb begin
        sz       = CTX_LONG;
        is_sub   = 1'b0;
        is_probe = 1'b0;
        is_exor  = 1'b0;
        is_eam   = 1'b0;
        is_eas   = 1'b0;
        ctx      = CTX_LONG;
        unique case (opcode_in)
            OP_SUB_B2, OP_SUB_B3: begin is_sub = 1'b1; sz = CTX_BYTE; end
            OP_SUB_W2, OP_SUB_W3: begin is_sub = 1'b1; sz = CTX_WORD; end
            OP_SUB_L2, OP_SUB_L3: begin is_sub = 1'b1; sz = CTX_LONG; end
            OP_PROBE_B: begin is_probe = 1'b1; sz = CTX_BYTE; end
            OP_PROBE_W: begin is_probe = 1'b1; sz = CTX_WORD; end
            OP_PROBE_L: begin is_probe = 1'b1; sz = CTX_LONG; end
            OP_EXOR_B2, OP_EXOR_B3: begin is_exor = 1'b1; sz = CTX_BYTE; end
            OP_EXOR_W2, OP_EXOR_W3: begin is_exor = 1'b1; sz = CTX_WORD; end
            OP_EXOR_L2, OP_EXOR_L3: begin is_exor = 1'b1; sz = CTX_LONG; end
            OP_EAM_B: begin is_eam = 1'b1; ctx = CTX_BYTE; end
            OP_EAM_W: begin is_eam = 1'b1; ctx = CTX_WORD; end
            OP_EAM_L: begin is_eam = 1'b1; ctx = CTX_LONG; end
            OP_EAM_Q: begin is_eam = 1'b1; ctx = prefix_in ? CTX_OCTA : CTX_QUAD; end
            OP_EAS_B: begin is_eas = 1'b1; ctx = CTX_BYTE; end
            OP_EAS_W: begin is_eas = 1'b1; ctx = CTX_WORD; end
            OP_EAS_L: begin is_eas = 1'b1; ctx = CTX_LONG; end
            OP_EAS_Q: begin is_eas = 1'b1; ctx = prefix_in ? CTX_OCTA : CTX_QUAD; end
            default: begin end
        endcase
    end

    assign is_cmp     = (opcode_in == OP_SCMP_S) || (opcode_in == OP_SCMP_U);
    assign is_ext     = (opcode_in == OP_SIGN_WIDEN_S) || (opcode_in == OP_SIGN_WIDEN_U);
    assign signed_fld = ~opcode_in[0];

    // ==========================================================
    // Sized arithmetic: operate on a 32-bit window, sign bit chosen by size
    function automatic logic [31:0] trim(input logic [31:0] v, input logic [4:0] s);
        unique case (s)
            CTX_BYTE: trim = {24'h00_0000, v[7:0]};
            CTX_WORD: trim = {16'h0000, v[15:0]};
            default:  trim = v;
        endcase
    endfunction

    function automatic logic msb(input logic [31:0] v, input logic [4:0] s);
        unique case (s)
            CTX_BYTE: msb = v[7];
            CTX_WORD: msb = v[15];
            default:  msb = v[31];
        endcase
    endfunction

    // Operand roles: opa = sub/mask, opb = dif/dst (2-op) or minuend/src (3-op)
    logic [31:0] sub_src;
    logic [31:0] sub_min;
    logic [32:0] sub_wide;
    logic [31:0] sub_res;
    logic        sub_v;
    logic        sub_c;
    logic [31:0] xor_res;

    assign sub_src  = trim(opa_in, sz);
    assign sub_min  = trim(opb_in, sz);
    assign sub_wide = {1'b0, sub_min} - {1'b0, sub_src};
    assign sub_res  = trim(sub_wide[31:0], sz);
    assign sub_v    = (msb(sub_min, sz) != msb(sub_src, sz))
                      && (msb(sub_res, sz) == msb(sub_src, sz));
    assign sub_c    = sub_min < sub_src;
    assign xor_res  = trim(opa_in ^ opb_in, sz);

    // ==========================================================
    // Bit-field unit
    logic        size_bad;
    logic        pos_bad;
    logic        fld_fault;
    logic [5:0]  bit_off;
    logic [63:0] src_bits;
    logic [63:0] shifted;
    logic [31:0] fld_mask;
    logic [31:0] fld_raw;
    logic [31:0] fld_val;
    logic [32:0] pos_plus;
    logic [8:0]  span;

    assign size_bad  = size_in > FIELD_MAX_SIZE;
    assign pos_bad   = base_is_reg_in && (size_in != 8'h00) && (pos_in > FIELD_MAX_POS);
    assign fld_fault = size_bad || pos_bad;
    assign pos_plus  = {1'b0, pos_in} + {25'h000_0000, size_in};
    // Register fields take Rn+1:Rn only when they spill past bit 31
    assign src_bits  = base_is_reg_in
                       ? ((pos_plus > {27'h000_0000, FIELD_REG_BITS}) ? {reg_hi_in, reg_lo_in}
                                                                      : {32'h0000_0000, reg_lo_in})
                       : mem_data_in;
    assign bit_off   = base_is_reg_in ? pos_in[5:0] : {3'h0, pos_in[2:0]};
    assign shifted   = src_bits >> bit_off;
    assign fld_mask  = (size_in[5:0] >= FIELD_REG_BITS) ? 32'hFFFF_FFFF
                       : ~(32'hFFFF_FFFF << size_in[4:0]);
    assign fld_raw   = shifted[31:0] & fld_mask;

    always_comb begin
        fld_val = fld_raw;
        if (size_in == 8'h00) begin
            fld_val = 32'h0000_0000;
        end else if (signed_fld && fld_raw[size_in[4:0] - 5'h01]) begin
            fld_val = fld_raw | ~fld_mask;
        end
    end

    // Bytes touched: 1 + (size-1+pos[2:0])/8, max 5 for size 32 at offset 7
    assign span = {1'b0, size_in} - 9'h001 + {6'h00, pos_in[2:0]};

    // ==========================================================
    // Issue sequencer
    ialu_state_t state_reg;

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_reg <= IALU_IDLE;
        end else begin
            unique case (state_reg)
                IALU_IDLE: state_reg <= op_valid_in ? IALU_BUSY : IALU_IDLE;
                IALU_BUSY: state_reg <= IALU_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Execute and write back (one cycle after acceptance)
    logic accept;

    assign accept = op_valid_in && (state_reg == IALU_IDLE);

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            done_out          <= 1'b0;
            result_out        <= 32'h0000_0000;
            result_we_out     <= 1'b0;
            flags_out         <= 4'h0;
            fault_out         <= 1'b0;
            field_addr_out    <= 32'h0000_0000;
            field_bytes_out   <= 3'h0;
            stack_pointer_out <= 32'h0000_0000;
            stack_we_out      <= 1'b0;
        end else begin
            done_out      <= accept;
            result_we_out <= 1'b0;
            stack_we_out  <= 1'b0;
            fault_out     <= 1'b0;
            if (accept) begin
                flags_out <= flags_in;
                if (is_sub) begin
                    result_out    <= sub_res;
                    result_we_out <= 1'b1;
                    flags_out     <= {msb(sub_res, sz), sub_res == 32'h0, sub_v, sub_c};
                end else if (is_probe) begin
                    flags_out <= {msb(opa_in, sz), trim(opa_in, sz) == 32'h0, 2'b00};
                end else if (is_exor) begin
                    result_out    <= xor_res;
                    result_we_out <= 1'b1;
                    flags_out     <= {msb(xor_res, sz), xor_res == 32'h0, 1'b0, flags_in[0]};
                end else if (is_eam || is_eas) begin
                    // Address only; the operand behind it is never fetched
                    flags_out <= {opa_in[31], opa_in == 32'h0, 1'b0, flags_in[0]};
                    if (is_eam) begin
                        result_out    <= opa_in;
                        result_we_out <= 1'b1;
                    end else begin
                        stack_pointer_out <= stack_pointer_in - LONG_BYTES;
                        result_out        <= opa_in;
                        stack_we_out      <= 1'b1;
                    end
                end else if (is_cmp || is_ext) begin
                    field_addr_out  <= opc_in + {{3{pos_in[31]}}, pos_in[31:3]};
                    field_bytes_out <= (size_in == 8'h00 || base_is_reg_in) ? 3'h0
                                       : 3'h1 + span[5:3];
                    if (fld_fault) begin
                        fault_out <= 1'b1;
                    end else if (is_cmp) begin
                        flags_out <= {$signed(fld_val) < $signed(opb_in),
                                      fld_val == opb_in, 1'b0, fld_val < opb_in};
                    end else begin
                        result_out    <= fld_val;
                        result_we_out <= 1'b1;
                        flags_out     <= {fld_val[31], fld_val == 32'h0, 1'b0, flags_in[0]};
                    end
                end
            end
        end
    end

    // ==========================================================
    // Event status, mask, interrupt and Avalon slave
    logic [2:0]  ev_stat_reg;
    logic [2:0]  ev_mask_reg;
    logic [31:0] opcnt_reg;
    logic [2:0]  ev_hit;
    logic        stat_rd;
    logic [2:0]  stat_kept;

    assign ev_hit  = {accept && is_sub && sub_v, accept && (is_cmp || is_ext) && fld_fault, accept};
    assign stat_rd = avs_read_in && !avs_waitrequest_out && (avs_address_in == ADDR_STATUS);
    // Clear only what the read returned, so an event landing inside the access is not lost
    assign stat_kept = stat_rd ? (ev_stat_reg & ~avs_readdata_out[2:0]) : ev_stat_reg;

    // Waitrequest drops in the cycle after a request, so each access takes two edges
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            avs_waitrequest_out <= 1'b1;
        end else begin
            avs_waitrequest_out <= !((avs_read_in || avs_write_in) && avs_waitrequest_out);
        end
    end

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ev_stat_reg <= 3'h0;
        end else begin
            // New events win over the read-clear
            ev_stat_reg <= stat_kept | ev_hit;
        end
    end

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ev_mask_reg <= MASK_RESET;
        end else if (avs_write_in && !avs_waitrequest_out && avs_address_in == ADDR_MASK) begin
            ev_mask_reg <= avs_writedata_in[2:0];
        end
    end

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            opcnt_reg <= 32'h0000_0000;
        end else if (avs_write_in && !avs_waitrequest_out && avs_address_in == ADDR_OPCNT) begin
            opcnt_reg <= 32'h0000_0000;
        end else if (accept) begin
            opcnt_reg <= opcnt_reg + 32'h0000_0001;
        end
    end

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            avs_readdata_out <= 32'h0000_0000;
            irq_out          <= 1'b0;
        end else begin
            irq_out <= |((stat_kept | ev_hit) & ev_mask_reg);
            unique case (avs_address_in)
                ADDR_STATUS: avs_readdata_out <= {29'h0, ev_stat_reg};
                ADDR_MASK:   avs_readdata_out <= {29'h0, ev_mask_reg};
                ADDR_OPCNT:  avs_readdata_out <= opcnt_reg;
                default:     avs_readdata_out <= 32'h0000_0000;
            endcase
        end
    end

    // ==========================================================
    // Checks
    chk_sub_ovf_flag: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        accept && is_sub |=> flags_out[1] == $past(sub_v)) else $error("subtract overflow flag wrong");
    chk_field_fault: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        accept && is_ext && size_in > FIELD_MAX_SIZE |=> fault_out && !result_we_out)
        else $error("oversize field not faulted");
    chk_regpos_fault: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        accept && is_cmp && base_is_reg_in && size_in != 8'h00 && pos_in > FIELD_MAX_POS |=> fault_out)
        else $error("register position not faulted");
    chk_probe_flags: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        accept && is_probe |=> flags_out[1:0] == 2'b00 && !result_we_out)
        else $error("probe wrote or set v/c");
    chk_exor_carry: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        accept && is_exor |=> flags_out[0] == $past(flags_in[0]) && result_we_out)
        else $error("exor carry changed");
    chk_push_sp: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        accept && is_eas |=> stack_we_out && stack_pointer_out == $past(stack_pointer_in) - LONG_BYTES)
        else $error("push stack pointer wrong");
    chk_cmp_noresult: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        accept && is_cmp |=> !result_we_out && (fault_out || flags_out[1] == ($past(fld_val) == $past(opb_in))))
        else $error("compare wrote result");
    chk_zero_size: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        accept && is_ext && size_in == 8'h00 |=> result_out == 32'h0 && field_bytes_out == 3'h0)
        else $error("zero size extract not zero");
    chk_irq_level: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        irq_out |-> ($past(ev_hit) & $past(ev_mask_reg)) != 3'h0
                    || ($past(ev_stat_reg) & $past(ev_mask_reg)) != 3'h0)
        else $error("irq without masked event");

endmodule

// file: ialu_mem_model.sv
`timescale 1ns/1ps
// ==========================================================
// Operand fetch memory port
module ialu_mem_model (
    input  wire logic [31:0] addr_in,
    output logic      [63:0] data_out
);
    // Each byte carries its own address, so a misplaced base or offset cannot read back right
    always_comb begin
        for (int k = 0; k < 8; k++) begin
            data_out[8*k +: 8] = addr_in[7:0] + 8'(k);
        end
    end
endmodule

// file: integer_alu_bitfield_unit_bench.sv
`timescale 1ns/1ps
module integer_alu_bitfield_unit_bench;
    import ialu_pkg::*;
    // ==========================================================
    // Stimulus and observed signals
    logic        mclk_in = 0, nrst_in = 0, op_valid_in = 0, prefix_in = 0, base_is_reg_in = 0;
    logic        avs_read_in = 0, avs_write_in = 0, ia, ib;
    logic [7:0]  opcode_in = 0, size_in = 0;
    logic [3:0]  flags_in = 0, avs_address_in = 0;
    logic [31:0] opa_in = 0, opb_in = 0, pos_in = 0, avs_writedata_in = 0, q;
    logic [31:0] opc_in = 32'h0000_1000, reg_lo_in = 32'hA000_00F0, reg_hi_in = 32'h0000_0015;
    logic [31:0] stack_pointer_in = 32'h0000_2000, maddr = 32'h0000_0FFE;
    logic [63:0] mem_data_in;
    logic        done_out, result_we_out, fault_out, stack_we_out, avs_waitrequest_out, irq_out;
    logic [31:0] result_out, field_addr_out, stack_pointer_out, avs_readdata_out;
    logic [3:0]  flags_out;
    logic [2:0]  field_bytes_out;
    int          n_fail = 0, tests_run = 0;
    logic [7:0]  subs[6] = '{OP_SUB_B2, OP_SUB_B3, OP_SUB_W2, OP_SUB_W3, OP_SUB_L2, OP_SUB_L3};
    logic [7:0]  xors[6] = '{OP_EXOR_B2, OP_EXOR_B3, OP_EXOR_W2, OP_EXOR_W3, OP_EXOR_L2, OP_EXOR_L3};
    logic [7:0]  eas[10] = '{OP_EAM_B, OP_EAM_W, OP_EAM_L, OP_EAM_Q, OP_EAM_Q,
                             OP_EAS_B, OP_EAS_W, OP_EAS_L, OP_EAS_Q, OP_EAS_Q};
    logic [7:0]  probes[3] = '{OP_PROBE_B, OP_PROBE_W, OP_PROBE_L};
    logic [31:0] ones[3] = '{32'h0000_00FF, 32'h0000_FFFF, 32'hFFFF_FFFF};

    ialu_core i_ialu_core (.mclk_in, .nrst_in, .op_valid_in, .opcode_in, .prefix_in, .opa_in, .opb_in,
        .opc_in, .pos_in, .size_in, .base_is_reg_in, .reg_lo_in, .reg_hi_in, .mem_data_in,
        .stack_pointer_in, .flags_in, .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
        .done_out, .result_out, .result_we_out, .flags_out, .fault_out, .field_addr_out, .field_bytes_out,
        .stack_pointer_out, .stack_we_out, .avs_readdata_out, .avs_waitrequest_out, .irq_out);
    ialu_mem_model i_ialu_mem_model (.addr_in(maddr), .data_out(mem_data_in));

    initial begin
        forever #4 mclk_in = ~mclk_in;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // One operation; result and flags are looked at in the single cycle that done stands
    task automatic go(input logic [7:0] o, input logic p, input logic [31:0] a, b, ps, input logic [7:0] sz,
                      input logic rg, input logic [3:0] f, input logic ew, ft, input logic [31:0] er,
                      input logic [3:0] ef);
        @(posedge mclk_in);
        {opcode_in, prefix_in, opa_in, opb_in, pos_in, size_in, base_is_reg_in, flags_in, op_valid_in} <=
            {o, p, a, b, ps, sz, rg, f, 1'b1};
        @(posedge mclk_in);
        op_valid_in <= 1'b0;
        for (int i = 0; i < 4 && done_out !== 1'b1 && fault_out !== 1'b1; i++) @(posedge mclk_in);
        chk(32'(done_out), 32'h1);
        chk(32'(fault_out), 32'(ft));
        chk(32'(result_we_out), 32'(ew));
        if (ew) chk(result_out, er);
        if (!ft) chk(32'(flags_out), 32'(ef));
    endtask

    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge mclk_in);
        {avs_address_in, avs_write_in, avs_read_in, avs_writedata_in} <= {a, w, !w, d};
        // Ends when avs_waitrequest_out drops; the watchdog ends the run if it never does
        do begin
            @(posedge mclk_in);
        end while (avs_waitrequest_out !== 1'b0);
        r = avs_readdata_out;
        {avs_write_in, avs_read_in} <= 2'b00;
    endtask

    task automatic results;
        $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        repeat (4000) @(posedge mclk_in);
        n_fail++;
        results();
    end

    initial begin
        repeat (16) @(posedge mclk_in);
        nrst_in <= 1'b1;
        bus(0, ADDR_MASK, 0, q);
        chk(q, 32'(MASK_RESET));
        go(OP_SUB_L3, 0, 32'h1, 32'h8000_0000, 0, 0, 0, 4'h0, 1, 0, 32'h7FFF_FFFF, 4'h2);
        foreach (subs[i]) go(subs[i], 0, 32'h1, 0, 0, 0, 0, 4'h6, 1, 0, ones[i/2], 4'h9);
        foreach (probes[i]) go(probes[i], 0, 32'h8080_8080, 0, 0, 0, 0, 4'hF, 0, 0, 0, 4'h8);
        foreach (xors[i]) go(xors[i], 0, 32'hFFFF_FFFF, 0, 0, 0, 0, 4'h1, 1, 0, ones[i/2], 4'h9);
        foreach (eas[i]) begin
            go(eas[i], i % 5 == 4, 32'h8000_0010, 0, 0, 0, 0, 4'h1, i < 5, 0, 32'h8000_0010, 4'h9);
            if (i >= 5) chk(stack_pointer_out, 32'h0000_2000 - LONG_BYTES);
            if (i >= 5) chk(result_out, 32'h8000_0010);
            if (i >= 5) chk(32'(stack_we_out), 32'h1);
        end
        go(OP_SIGN_WIDEN_S, 0, 0, 0, 32'h1D, 8'h08, 1, 4'h1, 1, 0, 32'hFFFF_FFAD, 4'h9);
        go(OP_SIGN_WIDEN_U, 0, 0, 0, 0, 8'h20, 1, 4'h0, 1, 0, 32'hA000_00F0, 4'h8);
        go(OP_SIGN_WIDEN_U, 0, 0, 0, 32'hFFFF_FFF7, 8'h0C, 0, 4'h0, 1, 0, 32'h0000_01FF, 4'h0);
        chk(field_addr_out, 32'h0000_0FFE);
        chk(32'(field_bytes_out), 32'h3);
        go(OP_SIGN_WIDEN_U, 0, 0, 0, 32'h28, 8'h00, 0, 4'h0, 1, 0, 0, 4'h4);
        chk(32'(field_bytes_out), 0);
        go(OP_SCMP_U, 0, 0, 32'h10, 32'h4, 8'h04, 1, 4'h2, 0, 0, 0, 4'h9);
        go(OP_SCMP_S, 0, 0, 32'h10, 32'h4, 8'h04, 1, 4'h2, 0, 0, 0, 4'h8);
        go(OP_SIGN_WIDEN_S, 0, 0, 0, 0, 8'h21, 0, 4'h0, 0, 1, 0, 0);
        go(OP_SCMP_U, 0, 0, 0, 32'h20, 8'h01, 1, 4'h0, 0, 1, 0, 0);
        bus(1, ADDR_MASK, 32'h7, q);
        repeat (3) @(posedge mclk_in);
        ia = irq_out;
        bus(1, ADDR_MASK, 32'h0, q);
        repeat (3) @(posedge mclk_in);
        ib = irq_out;
        chk(32'({ia, ib}), 32'h2);
        bus(0, ADDR_STATUS, 0, q);
        chk(q, 32'h7);
        bus(0, ADDR_STATUS, 0, q);
        chk(q, 0);
        bus(1, ADDR_MASK, 32'h7, q);
        repeat (3) @(posedge mclk_in);
        chk(32'(irq_out), 0);
        bus(0, 4'hC, 0, q);
        chk(q, 0);
        bus(0, ADDR_OPCNT, 0, q);
        chk(q, 32'h0000_0022);
        bus(1, ADDR_OPCNT, 0, q);
        bus(0, ADDR_OPCNT, 0, q);
        chk(q, 0);
        results();
    end
endmodule
